/* bsi_pkg.sv */
// Package with constants and types for the boot self-test status indicator
package bsi_pkg;
   // Phase codes shown on the green lamps, counting down from all-on
   localparam logic [3:0] PHASE_FIRST   = 4'hf;
   localparam logic [3:0] PHASE_LAST    = 4'h1;
   localparam logic [3:0] PHASE_STEP    = 4'h1;
   localparam logic [3:0] GREEN_OFF     = 4'h0;
   // Flash half period for message indication, in ns and in cycles of clk_sys
   localparam int         FLASH_HALF_NS = 250_000_000;
   localparam int         CLK_NS        = 50;
   localparam int         FLASH_HALF_CYC = FLASH_HALF_NS / CLK_NS;
   localparam int         POS_W         = 12;

   typedef enum logic [4:0] {
      BSI_ST_INIT = 5'h01,
      BSI_ST_HALT = 5'h02,
      BSI_ST_RUN  = 5'h04,
      BSI_ST_FAIL = 5'h08,
      BSI_ST_IDLE = 5'h10
   } bsi_state_e;
endpackage : bsi_pkg

/* bsi_flasher.sv */
// Free-running flash generator for message indication
`timescale 1ns/1ns
module bsi_flasher #(
   parameter int HALF_CYC = bsi_pkg::FLASH_HALF_CYC  // Cycles per flash half period
) (
   input  wire logic clk_sys,   // System clock
   input  wire logic rstn,      // Async reset, active low
   input  wire logic clk_en,    // Clock enable
   output logic      flash_on   // Flash phase, high = lamp lit
);
   localparam int CW = $clog2(HALF_CYC + 1);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          ph_ff;
   logic          nxt_ph;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_ph  = ph_ff;
      if (clk_en) begin
         if (cnt_ff == CW'(HALF_CYC - 1)) begin
            nxt_cnt = '0;
            nxt_ph  = ~ph_ff;
         end else begin
            nxt_cnt = cnt_ff + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
         ph_ff  <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ph_ff  <= nxt_ph;
      end
   end

   assign flash_on = ph_ff;
endmodule : bsi_flasher

/* bsi_status.sv */
// Start-up phase sequencer, self-test fault handling and lamp drive
`timescale 1ns/1ns
// Behaviour
// - After power-up or any reset the phases run in sequence and the running one is shown.
// - A failing phase halts the sequence and its code stays on the lamps as the error code.
// - With red off, green shows the phase code from 1111 counting down by one to 0001.
// - The fifteen phases run in a fixed order from functional test down to OS start.
// - Every lamp marked set in a code is driven steadily, not blinking.
// - A cyclic self-test fault lights red steadily with all green off.
// - A cyclic self-test fault in operation forces the primary pneumatic output to its vented fail-safe state.
// - All five lamps off in operation means diagnostic information without a lamp code; the code also shows them off in plain operation, diag_info is unused.
// - Non-fault messages flash the red lamp while green carries the message code.
// - The three-key chord, or losing and restoring the input signal, gives a full reset.
// - After a reset the sequence restarts at the first phase and halts at the same failure.
// - Confirm on the minus 45 degree item stores the sensor value as the minus 45 point.
// - Confirm on the plus 45 degree item stores the sensor value as the plus 45 point.
module bsi_status #(
   parameter int POS_W = bsi_pkg::POS_W,                 // Position sensor width
   parameter int FLASH_HALF_CYC = bsi_pkg::FLASH_HALF_CYC // Message flash half period
) (
   input  wire logic             clk_sys,        // System clock, 20 MHz
   input  wire logic             rstn,           // Async reset, active low
   input  wire logic             clk_en,         // Clock enable, freezes state when low
   input  wire logic             key_confirm,    // Confirm key held
   input  wire logic             key_minus,      // Minus key held
   input  wire logic             key_plus,       // Plus key held
   input  wire logic             input_sig_ok,   // Input signal present
   input  wire logic             phase_ok,       // Current phase finished, one-cycle pulse
   input  wire logic             phase_fail,     // Current phase failed, one-cycle pulse
   input  wire logic             selftest_fault, // Cyclic self-test electronics fault, level
   input  wire logic             diag_info,      // Diagnostic info present without lamp code
   input  wire logic             msg_active,     // Non-fault message active
   input  wire logic [3:0]       msg_code,       // Message code for the green lamps
   input  wire logic             menu_cal_m45,   // Minus 45 degree item selected
   input  wire logic             menu_cal_p45,   // Plus 45 degree item selected
   input  wire logic [POS_W-1:0] pos_meas,       // Position sensor measurement
   output logic                  led_red,        // Red lamp
   output logic [3:0]            led_green,      // Green lamps, bit 3 is lamp 1
   output logic [3:0]            phase_code,     // Running or frozen phase code
   output logic                  boot_done,      // Operating system started
   output logic                  boot_halted,    // Sequence stopped on an error
   output logic                  primary_pneumatic_output_vent, // Vent primary output
   output logic                  soft_reset,     // Full reset request, level
   output logic [POS_W-1:0]      cal_m45,        // Stored minus 45 point
   output logic [POS_W-1:0]      cal_p45,        // Stored plus 45 point
   output logic                  cal_m45_vld,    // Minus 45 point stored
   output logic                  cal_p45_vld     // Plus 45 point stored
);
   // ==========================================================
   // Reset sources
   // ==========================================================
   logic sig_ok_ff;
   logic nxt_sig_ok;
   logic restart;

   // Chord and signal loss both restart; signal loss restarts on the restore edge
   assign restart = (key_confirm & key_minus & key_plus) | (input_sig_ok & ~sig_ok_ff);
   assign nxt_sig_ok = clk_en ? input_sig_ok : sig_ok_ff;

   // ==========================================================
   // Phase sequencer
   // ==========================================================
   bsi_pkg::bsi_state_e state_ff;
   bsi_pkg::bsi_state_e nxt_state;
   logic [3:0]          code_ff;
   logic [3:0]          nxt_code;
   logic                fault_ff;
   logic                nxt_fault;

   always_comb begin
      nxt_state = state_ff;
      nxt_code  = code_ff;
      nxt_fault = fault_ff;
      if (clk_en) begin
         if (restart) begin
            nxt_state = bsi_pkg::BSI_ST_INIT;
            nxt_code  = bsi_pkg::PHASE_FIRST;
            nxt_fault = 1'b0;
         end else begin
            case (state_ff)
               bsi_pkg::BSI_ST_INIT: begin
                  if (phase_fail) begin
                     nxt_state = bsi_pkg::BSI_ST_HALT;
                  end else if (phase_ok) begin
                     if (code_ff == bsi_pkg::PHASE_LAST) begin
                        nxt_state = bsi_pkg::BSI_ST_RUN;
                     end else begin
                        nxt_code = code_ff - bsi_pkg::PHASE_STEP;
                     end
                  end
               end
               bsi_pkg::BSI_ST_HALT: begin
                  nxt_state = bsi_pkg::BSI_ST_HALT;
               end
               bsi_pkg::BSI_ST_RUN: begin
                  if (selftest_fault) begin
                     nxt_state = bsi_pkg::BSI_ST_FAIL;
                     nxt_fault = 1'b1;
                  end
               end
               bsi_pkg::BSI_ST_FAIL: begin
                  // Latched until reset so a flickering fault cannot re-pressurise
                  nxt_fault = 1'b1;
               end
               default: begin
                  nxt_state = bsi_pkg::BSI_ST_INIT;
                  nxt_code  = bsi_pkg::PHASE_FIRST;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= bsi_pkg::BSI_ST_INIT;
         code_ff   <= bsi_pkg::PHASE_FIRST;
         fault_ff  <= 1'b0;
         sig_ok_ff <= 1'b1;
      end else begin
         state_ff  <= nxt_state;
         code_ff   <= nxt_code;
         fault_ff  <= nxt_fault;
         sig_ok_ff <= nxt_sig_ok;
      end
   end

   // ==========================================================
   // Calibration points
   // ==========================================================
   logic [POS_W-1:0] m45_ff;
   logic [POS_W-1:0] p45_ff;
   logic [POS_W-1:0] nxt_m45;
   logic [POS_W-1:0] nxt_p45;
   logic             m45v_ff;
   logic             p45v_ff;
   logic             nxt_m45v;
   logic             nxt_p45v;
   logic             conf_ff;
   logic             nxt_conf;
   logic             conf_press;

   // Edge of confirm alone, so the reset chord does not store a point
   assign conf_press = key_confirm & ~conf_ff & ~key_minus & ~key_plus;
   assign nxt_conf   = clk_en ? key_confirm : conf_ff;

   always_comb begin
      nxt_m45  = m45_ff;
      nxt_p45  = p45_ff;
      nxt_m45v = m45v_ff;
      nxt_p45v = p45v_ff;
      if (clk_en && conf_press) begin
         if (menu_cal_m45) begin
            nxt_m45  = pos_meas;
            nxt_m45v = 1'b1;
         end else if (menu_cal_p45) begin
            nxt_p45  = pos_meas;
            nxt_p45v = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         m45_ff  <= '0;
         p45_ff  <= '0;
         m45v_ff <= 1'b0;
         p45v_ff <= 1'b0;
         conf_ff <= 1'b0;
      end else begin
         m45_ff  <= nxt_m45;
         p45_ff  <= nxt_p45;
         m45v_ff <= nxt_m45v;
         p45v_ff <= nxt_p45v;
         conf_ff <= nxt_conf;
      end
   end

   // ==========================================================
   // Lamp drive
   // ==========================================================
   logic flash_on;
   logic red_ff;
   logic nxt_red;
   logic [3:0] grn_ff;
   logic [3:0] nxt_grn;

   bsi_flasher #(
      .HALF_CYC (FLASH_HALF_CYC)
   ) u_flash (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .flash_on (flash_on)
   );

   always_comb begin
      nxt_red = red_ff;
      nxt_grn = grn_ff;
      if (clk_en) begin
         if (nxt_state == bsi_pkg::BSI_ST_FAIL) begin
            nxt_red = 1'b1;
            nxt_grn = bsi_pkg::GREEN_OFF;
         end else if (nxt_state == bsi_pkg::BSI_ST_RUN) begin
            if (msg_active) begin
               nxt_red = flash_on;
               nxt_grn = msg_code;
            end else begin
               // Diagnosis-only or plain operation both show all lamps dark
               nxt_red = 1'b0;
               nxt_grn = bsi_pkg::GREEN_OFF;
            end
         end else begin
            nxt_red = 1'b0;
            nxt_grn = nxt_code;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         red_ff <= 1'b0;
         grn_ff <= bsi_pkg::PHASE_FIRST;
      end else begin
         red_ff <= nxt_red;
         grn_ff <= nxt_grn;
      end
   end

   assign led_red     = red_ff;
   assign led_green   = grn_ff;
   assign phase_code  = code_ff;
   assign boot_done   = (state_ff == bsi_pkg::BSI_ST_RUN) | (state_ff == bsi_pkg::BSI_ST_FAIL);
   assign boot_halted = (state_ff == bsi_pkg::BSI_ST_HALT);
   assign primary_pneumatic_output_vent = fault_ff;
   assign soft_reset  = restart;
   assign cal_m45     = m45_ff;
   assign cal_p45     = p45_ff;
   assign cal_m45_vld = m45v_ff;
   assign cal_p45_vld = p45v_ff;
   // diag_info only documents the dark-lamp meaning; lamps are dark either way
   logic unused_diag;
   assign unused_diag = diag_info;
endmodule : bsi_status

/* bsi_chk.sv */
// Assertion checker for the status indicator ports
`timescale 1ns/1ns
module bsi_chk (
   input wire logic       clk_sys,        // clock
   input wire logic       rstn,           // reset
   input wire logic       clk_en,         // enable
   input wire logic       phase_ok,       // success
   input wire logic       phase_fail,     // failure
   input wire logic       selftest_fault, // fault
   input wire logic       led_red,        // red
   input wire logic [3:0] led_green,      // green
   input wire logic [3:0] phase_code,     // code
   input wire logic       boot_done,      // done
   input wire logic       boot_halted,    // halted
   input wire logic       primary_pneumatic_output_vent, // vent
   input wire logic       soft_reset      // restart
);
   // ==========
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Red lit means fault or message, so this isolates the boot phases
   wire in_init = !boot_done && !boot_halted && !led_red;
   wire quiet   = clk_en && !soft_reset;
   code_adv_a: assert property (
      in_init && quiet && phase_ok && !phase_fail && phase_code != 4'h1
      |=> phase_code == $past(phase_code) - 4'h1) else $error("code did not step");
   code_hold_a: assert property (
      !(clk_en && (phase_ok || soft_reset)) |=> $stable(phase_code)) else $error("code moved");
   green_code_a: assert property (
      !led_red && !boot_done |-> led_green == phase_code) else $error("green not code");
   fail_halt_a: assert property (
      in_init && quiet && phase_fail |=> boot_halted && $stable(phase_code))
      else $error("fail did not halt");
   halt_hold_a: assert property (
      boot_halted && !soft_reset |=> boot_halted && $stable(led_green)) else $error("halt lost");
   fault_lamp_a: assert property (
      boot_done && quiet && selftest_fault
      |=> led_red && led_green == 4'h0 && primary_pneumatic_output_vent) else $error("no fault");
   vent_latch_a: assert property (
      primary_pneumatic_output_vent && !soft_reset |=> primary_pneumatic_output_vent && led_red)
      else $error("vent dropped");
   restart_a: assert property (
      clk_en && soft_reset
      |=> phase_code == 4'hf && !boot_halted && !primary_pneumatic_output_vent)
      else $error("restart missed");
   cover property ($rose(boot_done));
   cover property ($rose(boot_halted));
   cover property ($rose(primary_pneumatic_output_vent));
endmodule : bsi_chk

/* bsi_keys.sv */
// Operator model: local keys, menu selection and input signal
`timescale 1ns/1ns
module bsi_keys (
   input  wire logic clk_sys,      // clock
   output logic      key_confirm,  // confirm
   output logic      key_minus,    // minus
   output logic      key_plus,     // plus
   output logic      input_sig_ok, // signal
   output logic      menu_cal_m45, // -45 item
   output logic      menu_cal_p45  // +45 item
);
   initial begin
      {key_confirm, key_minus, key_plus, menu_cal_m45, menu_cal_p45} = 5'h00;
      input_sig_ok = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hold
   task automatic chord();
      {key_confirm, key_minus, key_plus} = 3'h7;
      hold(2);
      {key_confirm, key_minus, key_plus} = 3'h0;
   endtask : chord
   task automatic sig_cycle();
      input_sig_ok = 1'b0;
      hold(2);
      input_sig_ok = 1'b1;
   endtask : sig_cycle
   // Item settles a cycle before confirm so the press sees it
   task automatic confirm_cal(input logic m45);
      {menu_cal_m45, menu_cal_p45} = {m45, !m45};
      hold(1);
      key_confirm = 1'b1;
      hold(1);
      {key_confirm, menu_cal_m45, menu_cal_p45} = 3'h0;
      hold(1);
   endtask : confirm_cal
endmodule : bsi_keys

/* bsi_status_tb.sv */
// Self-checking testbench for the status indicator
`timescale 1ns/1ns
module bsi_status_tb;
   localparam int FLASH_HC = 4;
   logic        clk_sys = 1'b0;
   logic        rstn, clk_en, phase_ok, phase_fail, selftest_fault, diag_info, msg_active;
   logic        key_confirm, key_minus, key_plus, input_sig_ok, menu_cal_m45, menu_cal_p45;
   logic        led_red, boot_done, boot_halted, primary_pneumatic_output_vent, soft_reset;
   logic        cal_m45_vld, cal_p45_vld;
   logic [3:0]  msg_code, led_green, phase_code;
   logic [11:0] pos_meas, cal_m45, cal_p45;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          cyc = 0;
   bsi_status #(.FLASH_HALF_CYC(FLASH_HC)) DUT (
      .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .key_confirm(key_confirm),
      .key_minus(key_minus), .key_plus(key_plus), .input_sig_ok(input_sig_ok),
      .phase_ok(phase_ok), .phase_fail(phase_fail), .selftest_fault(selftest_fault),
      .diag_info(diag_info), .msg_active(msg_active), .msg_code(msg_code),
      .menu_cal_m45(menu_cal_m45), .menu_cal_p45(menu_cal_p45), .pos_meas(pos_meas),
      .led_red(led_red), .led_green(led_green), .phase_code(phase_code),
      .boot_done(boot_done), .boot_halted(boot_halted),
      .primary_pneumatic_output_vent(primary_pneumatic_output_vent),
      .soft_reset(soft_reset), .cal_m45(cal_m45), .cal_p45(cal_p45),
      .cal_m45_vld(cal_m45_vld), .cal_p45_vld(cal_p45_vld)
   );
   bsi_keys keys (
      .clk_sys(clk_sys), .key_confirm(key_confirm), .key_minus(key_minus),
      .key_plus(key_plus), .input_sig_ok(input_sig_ok), .menu_cal_m45(menu_cal_m45),
      .menu_cal_p45(menu_cal_p45)
   );
   always #25 clk_sys = ~clk_sys;
   // ==========
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   // Success pulses back to back until the code reaches stop
   task automatic boot_to(input logic [3:0] stop);
      logic [3:0] exp;
      exp = 4'hf;
      chk(led_green, exp, "first phase");
      phase_ok = 1'b1;
      while (exp != stop) begin
         tick(1);
         exp = exp - 4'h1;
         chk(led_green, exp, "phase lamps");
      end
      phase_ok = 1'b0;
   endtask : boot_to
   task automatic fail_at(input logic [3:0] stop);
      boot_to(stop);
      phase_fail = 1'b1;
      tick(1);
      phase_fail = 1'b0;
      phase_ok = 1'b1;
      tick(3);
      phase_ok = 1'b0;
      chk(boot_halted, 1'b1, "halted");
      chk(led_green, stop, "error code");
   endtask : fail_at
   // ==========
   // Scenarios
   task automatic t_halt();
      clk_en = 1'b0;
      phase_ok = 1'b1;
      tick(2);
      {phase_ok, clk_en} = 2'b01;
      chk(phase_code, 4'hf, "frozen");
      tick(1);
      fail_at(4'h9);
      keys.chord();
      fail_at(4'h9);
      $display("halt and restart done");
   endtask : t_halt
   task automatic t_run();
      keys.sig_cycle();
      #1;
      chk(soft_reset, 1'b1, "restore restart");
      tick(1);
      boot_to(4'h1);
      tick(1);
      phase_ok = 1'b1;
      diag_info = 1'b1;
      tick(1);
      phase_ok = 1'b0;
      tick(1);
      chk(boot_done, 1'b1, "booted");
      chk({led_red, led_green}, 5'h00, "dark");
      pos_meas = 12'h3a5;
      keys.confirm_cal(1'b1);
      chk({cal_m45_vld, cal_m45}, 13'h13a5, "m45");
      pos_meas = 12'hc5a;
      keys.confirm_cal(1'b0);
      chk({cal_p45_vld, cal_p45}, 13'h1c5a, "p45");
      chk(cal_m45, 12'h3a5, "m45 kept");
      $display("run and calibration done");
   endtask : t_run
   task automatic t_msg();
      int ones;
      ones = 0;
      {msg_code, msg_active} = 5'h0b;
      tick(1);
      for (int i = 0; i < 2 * FLASH_HC + 2; i++) begin
         tick(1);
         if (led_red === 1'b1) ones++;
         chk(led_green, 4'h5, "msg code");
      end
      chk(ones > 0 && ones < 2 * FLASH_HC + 2, 1'b1, "flash");
      msg_active = 1'b0;
      tick(2);
      chk({led_red, led_green}, 5'h00, "msg off");
      $display("message done");
   endtask : t_msg
   task automatic t_fault();
      selftest_fault = 1'b1;
      tick(1);
      selftest_fault = 1'b0;
      tick(3);
      chk({primary_pneumatic_output_vent, led_red, led_green}, 6'h30, "fault");
      keys.chord();
      chk({primary_pneumatic_output_vent, phase_code}, 5'h0f, "cleared");
      chk(cal_m45, 12'h3a5, "cal kept");
      $display("fault done");
   endtask : t_fault
   initial begin
      {rstn, clk_en, phase_ok, phase_fail, selftest_fault, diag_info, msg_active} = 7'h00;
      msg_code = 4'h0;
      pos_meas = 12'h000;
      tick(8);
      {rstn, clk_en} = 2'b11;
      chk({primary_pneumatic_output_vent, led_red}, 2'b00, "reset");
      t_halt();
      t_run();
      t_msg();
      t_fault();
      end_sim();
   end
endmodule : bsi_status_tb
bind bsi_status bsi_chk u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .phase_ok(phase_ok),
   .phase_fail(phase_fail), .selftest_fault(selftest_fault), .led_red(led_red),
   .led_green(led_green), .phase_code(phase_code), .boot_done(boot_done),
   .boot_halted(boot_halted),
   .primary_pneumatic_output_vent(primary_pneumatic_output_vent),
   .soft_reset(soft_reset)
);
